//--- hdl/frs_pkg.sv
/*
 Constants and types for the feed regulator serial fault port.
 Assumes a single core clock at 40 MHz and pins sampled by the core.
*/
package frs_pkg;

   // ----------------------------------------
   // Link addressing
   // ----------------------------------------
   localparam logic [4:0] ADDR_PREFIX = 5'h02;
   localparam logic [7:0] REG_ADDR = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ----------------------------------------
   // Control and status fields
   // ----------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_ON_BIT = 3;
   localparam int CTRL_VSEL_LSB = 0;
   localparam int STS_UV = 7;
   localparam int STS_TSD = 6;
   localparam int STS_PNG = 4;
   localparam int STS_OC = 2;
   localparam int STS_DIS = 0;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_KHZ = 40000;
   localparam int OC_TIME_US = 45000;
   localparam int OC_CYCLES = (OC_TIME_US * CLK_KHZ + 999) / 1000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_MACK
   } frs_phase_e;

   typedef struct packed {
      logic scl;
      logic sda;
      logic supply_ok;
      logic overload;
      logic overtemp;
      logic level_bad;
      logic [1:0] addr_sel;
   } frs_pins_s;

endpackage

//--- hdl/frs_port.sv
/*
 Two-wire target port with control and status registers, fault latches,
 fault request line and feed output gating.
 Assumes every input is asynchronous to core_clk and the link clock is
 slow enough to be oversampled by the core clock.
*/
// Notes on behaviour
// - Start or stop mid-transfer restarts byte sequence.
// - Write is address, register, data, each acknowledged.
// - Address MSB first, upper five bits 00010.
// - Low address bits come from select setting.
// - Acknowledge matching address in ninth clock.
// - Write register address must be zero, acknowledged.
// - Control byte acknowledged and loaded into register.
// - Read register address must be zero, acknowledged.
// - Status shifted MSB first, master acknowledges.
// - Fault request only pulls low, else floats.
// - Fault request low on supply, current, thermal faults.
// - Faults stay latched until status read acknowledged.
// - Master acknowledge releases request and clears latches.
// - Off and level-bad neither latch nor request.
// - Leaving lockout latches undervoltage and requests.
// - Lockout idles port, request released until recovery.
// - Overload over 45 ms shuts output, latches fault.
// - Over-temperature shuts output, latches fault.
// - Enable ignored until faults cleared by read.
// - Control register resets to all zeros.
// - Bad byte gets no acknowledge.
module frs_port #(
   parameter int OC_CYCLES = frs_pkg::OC_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq_out,
   output logic irq_oe,
   input wire logic [1:0] addr_sel,
   input wire logic supply_ok,
   input wire logic overload,
   input wire logic overtemp,
   input wire logic level_bad,
   output logic feed_on,
   output logic [2:0] vsel
);

   localparam int OCW = $clog2(OC_CYCLES + 1);
   localparam logic [OCW-1:0] OC_LAST = OCW'(OC_CYCLES - 1);
   if (OC_CYCLES < 1) begin : g_bad_oc
      $error("OC_CYCLES must be at least one");
   end
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      frs_pkg::frs_pins_s sync1;
      frs_pkg::frs_pins_s sync2;
      logic scl_q;
      logic sda_q;
      frs_pkg::frs_phase_e phase;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [1:0] idx;
      logic rd;
      logic [7:0] ctrl;
      logic uv;
      logic oc;
      logic thermal_shutdown_fault;
      logic [OCW-1:0] oc_cnt;
      logic sda_oe;
      logic irq_oe;
      logic feed_on;
   } frs_state_s;
   frs_state_s st;
   frs_state_s next_st;
   frs_pkg::frs_pins_s pin_now;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic oc_trip;
   logic ack_clear;
   logic [7:0] status;
   assign pin_now = '{scl: scl_in, sda: sda_in, supply_ok: supply_ok,
                      overload: overload, overtemp: overtemp,
                      level_bad: level_bad, addr_sel: addr_sel};
   // ----------------------------------------
   // Link edge detection
   // ----------------------------------------
   assign scl_rise = st.sync2.scl & ~st.scl_q;
   assign scl_fall = ~st.sync2.scl & st.scl_q;
   assign start_seen = st.scl_q & st.sync2.scl & st.sda_q & ~st.sync2.sda;
   assign stop_seen = st.scl_q & st.sync2.scl & ~st.sda_q & st.sync2.sda;
   assign oc_trip = st.sync2.overload & st.feed_on & (st.oc_cnt == OC_LAST);
   assign ack_clear = (st.phase == frs_pkg::ST_MACK) & scl_rise
                      & ~st.sync2.sda;

   // Output-off and level-bad are live views, never latched.
   always_comb begin
      status = 8'h00;
      status[frs_pkg::STS_UV] = st.uv;
      status[frs_pkg::STS_TSD] = st.thermal_shutdown_fault;
      status[frs_pkg::STS_PNG] = st.sync2.level_bad;
      status[frs_pkg::STS_OC] = st.oc;
      status[frs_pkg::STS_DIS] = ~st.feed_on;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.sync1 = pin_now;
      next_st.sync2 = st.sync1;
      next_st.scl_q = st.sync2.scl;
      next_st.sda_q = st.sync2.sda;
      case (st.phase)
         frs_pkg::ST_IDLE: next_st.sda_oe = 1'b0;
         frs_pkg::ST_RX: begin
            if (scl_rise) begin
               next_st.sh = {st.sh[6:0], st.sync2.sda};
               next_st.cnt = st.cnt + 4'h1;
            end
            if (scl_fall && st.cnt == frs_pkg::BITS_PER_BYTE) begin
               next_st.cnt = 4'h0;
               next_st.phase = frs_pkg::ST_IDLE;
               case (st.idx)
                  2'h0: begin
                     // Foreign addresses are dropped without a pulse.
                     if (st.sh[7:1] == {frs_pkg::ADDR_PREFIX,
                                        st.sync2.addr_sel}) begin
                        next_st.rd = st.sh[0];
                        next_st.sda_oe = 1'b1;
                        next_st.phase = frs_pkg::ST_ACK;
                     end
                  end
                  2'h1: begin
                     if (st.sh == frs_pkg::REG_ADDR) begin
                        next_st.sda_oe = 1'b1;
                        next_st.phase = frs_pkg::ST_ACK;
                     end
                  end
                  2'h2: begin
                     next_st.ctrl = st.sh;
                     next_st.sda_oe = 1'b1;
                     next_st.phase = frs_pkg::ST_ACK;
                  end
                  default: next_st.phase = frs_pkg::ST_IDLE;
               endcase
            end
         end
         frs_pkg::ST_ACK: begin
            if (scl_fall) begin
               next_st.sda_oe = 1'b0;
               next_st.cnt = 4'h0;
               if (st.rd && st.idx == 2'h0) begin
                  // First status bit goes out as the slot closes.
                  next_st.sh = {status[6:0], 1'b0};
                  next_st.sda_oe = ~status[7];
                  next_st.cnt = 4'h1;
                  next_st.phase = frs_pkg::ST_TX;
               end else if (st.idx == 2'h2) begin
                  next_st.phase = frs_pkg::ST_IDLE;
               end else begin
                  next_st.idx = st.idx + 2'h1;
                  next_st.phase = frs_pkg::ST_RX;
               end
            end
         end
         frs_pkg::ST_TX: begin
            if (scl_fall) begin
               if (st.cnt == frs_pkg::BITS_PER_BYTE) begin
                  next_st.sda_oe = 1'b0;
                  next_st.phase = frs_pkg::ST_MACK;
               end else begin
                  next_st.sda_oe = ~st.sh[7];
                  next_st.sh = {st.sh[6:0], 1'b0};
                  next_st.cnt = st.cnt + 4'h1;
               end
            end
         end
         frs_pkg::ST_MACK: begin
            if (scl_rise) begin
               next_st.phase = frs_pkg::ST_IDLE;
            end
         end
         default: next_st.phase = frs_pkg::ST_IDLE;
      endcase
      // A start outranks everything in flight; a stop ends the transfer.
      if (start_seen) begin
         next_st.phase = frs_pkg::ST_RX;
         next_st.cnt = 4'h0;
         next_st.idx = 2'h0;
         next_st.rd = 1'b0;
         next_st.sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_st.phase = frs_pkg::ST_IDLE;
         next_st.sda_oe = 1'b0;
      end
      // Fault latches: a new fault wins over the clearing acknowledge.
      next_st.uv = (st.uv & ~ack_clear) | ~st.sync2.supply_ok;
      next_st.oc = (st.oc & ~ack_clear) | oc_trip;
      next_st.thermal_shutdown_fault = (st.thermal_shutdown_fault & ~ack_clear) | st.sync2.overtemp;
      if (st.sync2.overload && st.feed_on && !oc_trip) begin
         next_st.oc_cnt = st.oc_cnt + OCW'(1);
      end else begin
         next_st.oc_cnt = '0;
      end
      // Lockout acts as a reset of the port and the control register.
      if (!st.sync2.supply_ok) begin
         next_st.phase = frs_pkg::ST_IDLE;
         next_st.sda_oe = 1'b0;
         next_st.ctrl = frs_pkg::CTRL_RESET;
      end
      next_st.feed_on = next_st.ctrl[frs_pkg::CTRL_ON_BIT]
                        & ~next_st.uv & ~next_st.oc & ~next_st.thermal_shutdown_fault;
      next_st.irq_oe = st.sync2.supply_ok
                       & (next_st.uv | next_st.oc | next_st.thermal_shutdown_fault);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.sync1.scl <= 1'b1;
         st.sync1.sda <= 1'b1;
         st.sync2.scl <= 1'b1;
         st.sync2.sda <= 1'b1;
         st.scl_q <= 1'b1;
         st.sda_q <= 1'b1;
         st.ctrl <= frs_pkg::CTRL_RESET;
         st.uv <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Open-drain pins: the level is only ever low while enabled.
   assign sda_out = 1'b0;
   assign irq_out = 1'b0;
   assign sda_oe = st.sda_oe;
   assign irq_oe = st.irq_oe;
   assign feed_on = st.feed_on;
   assign vsel = st.ctrl[frs_pkg::CTRL_VSEL_LSB +: 3];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_ack_slot;
      st.phase == frs_pkg::ST_MACK && scl_rise && !st.sync2.sda;
   endsequence
   sequence s_nak_slot;
      st.phase == frs_pkg::ST_MACK && scl_rise && st.sync2.sda;
   endsequence
   property p_start_restart;
      start_seen && st.sync2.supply_ok |=>
         st.phase == frs_pkg::ST_RX && st.cnt == 4'h0 && st.idx == 2'h0;
   endproperty
   a_start_restart: assert property (p_start_restart)
      else $error("start did not restart the byte sequence");
   property p_stop_idle;
      stop_seen && !start_seen |=> st.phase == frs_pkg::ST_IDLE && !sda_oe;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop did not end the transfer");
   property p_ack_drive;
      st.phase == frs_pkg::ST_ACK |-> sda_oe;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("acknowledge slot not driven low");
   property p_ctrl_load;
      st.phase == frs_pkg::ST_RX && scl_fall && st.idx == 2'h2
      && st.cnt == frs_pkg::BITS_PER_BYTE && st.sync2.supply_ok
      && !start_seen |=> st.ctrl == $past(st.sh) ##1 sda_oe;
   endproperty
   a_ctrl_load: assert property (p_ctrl_load)
      else $error("control byte not loaded and acknowledged");
   property p_irq_follow;
      (st.uv || st.oc || st.thermal_shutdown_fault) && st.sync2.supply_ok
      && $past(st.sync2.supply_ok) |-> irq_oe;
   endproperty
   a_irq_follow: assert property (p_irq_follow)
      else $error("fault latched without fault request");
   property p_ack_clear;
      s_ack_slot and (st.sync2.supply_ok && !st.sync2.overtemp && !oc_trip)
      |=> !st.uv && !st.oc && !st.thermal_shutdown_fault && !irq_oe;
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("acknowledged read did not clear faults");
   property p_nak_keep;
      s_nak_slot |=> (st.uv || !$past(st.uv)) && (st.oc || !$past(st.oc))
         && (st.thermal_shutdown_fault || !$past(st.thermal_shutdown_fault));
   endproperty
   a_nak_keep: assert property (p_nak_keep)
      else $error("unacknowledged read cleared a fault");
   property p_lockout;
      !st.sync2.supply_ok |=> st.phase == frs_pkg::ST_IDLE && !sda_oe
         && !irq_oe && st.uv && st.ctrl == frs_pkg::CTRL_RESET;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("port active or request low during lockout");
   property p_oc_trip;
      oc_trip && st.sync2.supply_ok |=> st.oc && !feed_on && irq_oe;
   endproperty
   a_oc_trip: assert property (p_oc_trip)
      else $error("overload timeout did not shut output");
   property p_thermal;
      st.sync2.overtemp && st.sync2.supply_ok |=> st.thermal_shutdown_fault && !feed_on;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("over-temperature did not shut output");
   property p_enable_blocked;
      st.oc || st.thermal_shutdown_fault || st.uv |-> !feed_on;
   endproperty
   a_enable_blocked: assert property (p_enable_blocked)
      else $error("output on while a fault is latched");
   property p_foreign;
      st.phase == frs_pkg::ST_RX && scl_fall && st.idx == 2'h0
      && st.cnt == frs_pkg::BITS_PER_BYTE && !start_seen && st.sync2.supply_ok
      && st.sh[7:1] != {frs_pkg::ADDR_PREFIX, st.sync2.addr_sel}
      |=> !sda_oe && st.phase == frs_pkg::ST_IDLE && $stable(st.ctrl);
   endproperty
   a_foreign: assert property (p_foreign)
      else $error("foreign address was answered");
endmodule // frs_port

//--- tb/frs_host.sv
/*
 Host master model for the two-wire link of the feed regulator port.
 Assumes an external pull-up on the data line, resolved in the bench.
*/
module frs_host (
   output logic scl,
   output logic sda_oe,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // Link framing, 200 ns bit period
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   // The clock idles high, so it stands still between frames.
   task automatic start_c();
      sda_oe = 1'b0;
      #50 scl = 1'b1;
      #50 sda_oe = 1'b1;
      #100 scl = 1'b0;
   endtask

   task automatic stop_c();
      #50 sda_oe = 1'b1;
      #50 scl = 1'b1;
      #100 sda_oe = 1'b0;
      #100;
   endtask

   // Data moves only while the clock is low; sampled late in the high.
   task automatic bit_c(input logic b, output logic r);
      #50 sda_oe = ~b;
      #50 scl = 1'b1;
      #90 r = sda;
      #10 scl = 1'b0;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_c(d[i], r);
      bit_c(1'b1, r);
      ack = ~r;
   endtask

   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, r);
         d[i] = r;
      end
      bit_c(~mack, r);
   endtask
endmodule // frs_host

//--- tb/frs_port_test.sv
/*
 Self-checking bench for the feed regulator serial fault port.
 Assumes the host model drives the link and the bench drives fault pins.
*/
module frs_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int OCN = 50;
   logic core_clk, rst, scl, host_oe, supply_ok, overload, overtemp;
   logic level_bad, sda_out, sda_oe, irq_out, irq_oe, feed_on;
   logic [1:0] addr_sel;
   logic [2:0] vsel, ak;
   logic [7:0] st;
   wire logic sda = ~(sda_oe | host_oe);
   int miscompares = 0;
   int n_checks = 0;

   frs_port #(.OC_CYCLES(OCN)) frs_port_i (.core_clk(core_clk),
      .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq_out(irq_out), .irq_oe(irq_oe),
      .addr_sel(addr_sel), .supply_ok(supply_ok), .overload(overload),
      .overtemp(overtemp), .level_bad(level_bad), .feed_on(feed_on),
      .vsel(vsel));
   frs_host frs_host_i (.scl(scl), .sda_oe(host_oe), .sda(sda));

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [7:0] g,
                      input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   function automatic logic [6:0] dev();
      return {frs_pkg::ADDR_PREFIX, addr_sel};
   endfunction

   task automatic wr_ctrl(input logic [6:0] a, input logic [7:0] ra,
                          input logic [7:0] d);
      frs_host_i.start_c();
      frs_host_i.wr_byte({a, 1'b0}, ak[2]);
      frs_host_i.wr_byte(ra, ak[1]);
      frs_host_i.wr_byte(d, ak[0]);
      frs_host_i.stop_c();
      tick(2);
   endtask

   task automatic rd_st(input logic mack);
      logic [2:0] a;
      frs_host_i.start_c();
      frs_host_i.wr_byte({dev(), 1'b0}, a[2]);
      frs_host_i.wr_byte(frs_pkg::REG_ADDR, a[1]);
      frs_host_i.stop_c();
      frs_host_i.start_c();
      frs_host_i.wr_byte({dev(), 1'b1}, a[0]);
      frs_host_i.rd_byte(mack, st);
      frs_host_i.stop_c();
      ak = a;
      tick(3);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_power();
      chk("irq_oe", 8'(irq_oe), 8'h01);
      chk("vsel", 8'(vsel), 8'h00);
      chk("irq_out", 8'(irq_out), 8'h00);
      chk("sda_out", 8'(sda_out), 8'h00);
      rd_st(1'b1);
      chk("acks", 8'(ak), 8'h07);
      chk("status", st, 8'h81);
      chk("irq_oe", 8'(irq_oe), 8'h00);
   endtask

   task automatic t_write();
      for (int s = 0; s < 4; s++) begin
         addr_sel = 2'(s);
         tick(4);
         wr_ctrl(dev(), 8'h00, 8'h0c | 8'(s));
         chk("acks", 8'(ak), 8'h07);
         chk("vsel", 8'(vsel), 8'h04 | 8'(s));
         chk("feed_on", 8'(feed_on), 8'h01);
      end
   endtask

   task automatic t_refuse();
      wr_ctrl({frs_pkg::ADDR_PREFIX, ~addr_sel}, 8'h00, 8'h00);
      chk("acks", 8'(ak), 8'h00);
      wr_ctrl(dev(), 8'h01, 8'h00);
      chk("acks", 8'(ak), 8'h04);
      chk("vsel", 8'(vsel), 8'h07);
   endtask

   task automatic t_abort();
      logic r;
      frs_host_i.start_c();
      frs_host_i.wr_byte({dev(), 1'b0}, r);
      frs_host_i.wr_byte(8'h00, r);
      repeat (4) frs_host_i.bit_c(1'b0, r);
      wr_ctrl(dev(), 8'h00, 8'h0a);
      chk("acks", 8'(ak), 8'h07);
      chk("vsel", 8'(vsel), 8'h02);
   endtask

   task automatic t_oc();
      overload = 1'b1;
      tick(OCN - 10);
      chk("feed_on", 8'(feed_on), 8'h01);
      tick(20);
      overload = 1'b0;
      chk("feed_on", 8'(feed_on), 8'h00);
      chk("irq_oe", 8'(irq_oe), 8'h01);
      rd_st(1'b0);
      chk("status", st, 8'h05);
      chk("irq_oe", 8'(irq_oe), 8'h01);
      wr_ctrl(dev(), 8'h00, 8'h0a);
      chk("feed_on", 8'(feed_on), 8'h00);
      rd_st(1'b1);
      chk("status", st, 8'h05);
      chk("irq_oe", 8'(irq_oe), 8'h00);
      chk("feed_on", 8'(feed_on), 8'h01);
   endtask

   task automatic t_tsd();
      overtemp = 1'b1;
      tick(4);
      overtemp = 1'b0;
      chk("feed_on", 8'(feed_on), 8'h00);
      chk("irq_oe", 8'(irq_oe), 8'h01);
      rd_st(1'b1);
      chk("status", st, 8'h41);
      chk("irq_oe", 8'(irq_oe), 8'h00);
   endtask

   task automatic t_live();
      level_bad = 1'b1;
      tick(5);
      chk("irq_oe", 8'(irq_oe), 8'h00);
      rd_st(1'b1);
      chk("status", st, 8'h10);
      level_bad = 1'b0;
      wr_ctrl(dev(), 8'h00, 8'h00);
      rd_st(1'b1);
      chk("status", st, 8'h01);
      chk("irq_oe", 8'(irq_oe), 8'h00);
   endtask

   task automatic t_brown();
      wr_ctrl(dev(), 8'h00, 8'h0b);
      supply_ok = 1'b0;
      tick(6);
      chk("irq_oe", 8'(irq_oe), 8'h00);
      chk("feed_on", 8'(feed_on), 8'h00);
      rd_st(1'b1);
      chk("acks", 8'(ak), 8'h00);
      supply_ok = 1'b1;
      tick(6);
      chk("irq_oe", 8'(irq_oe), 8'h01);
      rd_st(1'b1);
      chk("status", st, 8'h81);
      chk("vsel", 8'(vsel), 8'h00);
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      supply_ok = 1'b1;
      overload = 1'b0;
      overtemp = 1'b0;
      level_bad = 1'b0;
      addr_sel = 2'b00;
      tick(2);
      rst = 1'b0;
      tick(6);
      t_power();
      t_write();
      t_refuse();
      t_abort();
      t_oc();
      t_tsd();
      t_live();
      t_brown();
      wrap_up();
   end

   initial begin
      #2000000;
      miscompares++;
      wrap_up();
   end
endmodule // frs_port_test
